// ===== verilog/periph_int_pkg.sv
/*
   Shared constants for the peripheral interrupt and transfer request controller.
   Assumes a 32-bit APB slave port with a 12-bit byte address and a 200 MHz system clock.
*/
package periph_int_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [9:0] I0_PEND_IDX   = 10'h0F9;
   localparam logic [9:0] EH_PEND_IDX   = 10'h0FA;
   localparam logic [9:0] VEC_BASE_IDX  = 10'h0FB;
   localparam logic [9:0] CNT_PTR_IDX   = 10'h0FC;
   localparam logic [9:0] REQ_CTL_IDX   = 10'h0FD;
   localparam logic [9:0] EDGE_CFG_IDX  = 10'h0FE;
   localparam logic [9:0] MODE_CTL_IDX  = 10'h0FF;
   localparam logic [9:0] IRQ_STAT_IDX  = 10'h100;
   localparam logic [9:0] IRQ_EN_IDX    = 10'h101;
   localparam logic [9:0] IRQ_CLR_IDX   = 10'h102;

   // Field positions in the request control, counter pointer and mode control registers.
   localparam int REQ_PEND_BIT  = 5;
   localparam int REQ_DMASK_BIT = 4;
   localparam int REQ_EOB_BIT   = 3;
   localparam int REQ_PRIO_LSB  = 0;
   localparam int CNT_SEL_BIT   = 0;
   localparam int MODE_SWAP_BIT = 0;

   // Interrupt status bit positions.
   localparam int EV_CHAN_BIT   = 0;
   localparam int EV_PERIPH_BIT = 1;
   localparam int EV_EOB_BIT    = 2;

   // Values after reset.
   localparam logic [7:0] PEND_RST     = 8'h00;
   localparam logic [2:0] VEC_MSB_RST  = 3'h0;
   localparam logic [4:0] VEC_LOW_FIX  = 5'h1E;
   localparam logic [7:0] CNT_PTR_RST  = 8'h00;
   localparam logic [5:0] REQ_CTL_RST  = 6'h00;
   localparam logic [8:0] EDGE_CFG_RST = 9'h000;
   localparam logic [2:0] IRQ_RST      = 3'h0;

   function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
      reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

endpackage

// ===== verilog/edge_trig_detect.sv
/*
   Per-line trigger edge detector for the standard interrupt channels.
   Assumes the lines are synchronous to the system clock.
*/
`timescale 1ns/1ps
module edge_trig_detect (
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   input  wire logic [8:0] line_i,
   input  wire logic [8:0] rise_sel_i,
   input  wire logic       block_i,
   output logic      [8:0] event_o
);
   logic [8:0] line_prev_reg;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         line_prev_reg <= 9'h000;
      end else begin
         line_prev_reg <= line_i;
      end
   end

   // A set select bit picks the rising edge, a clear one the falling edge.
   // Edges seen while the configuration is being rewritten are dropped.
   always_comb begin
      event_o = '0;
      if (!block_i) begin
         event_o = (rise_sel_i & line_i & ~line_prev_reg) | (~rise_sel_i & ~line_i & line_prev_reg);
      end
   end
endmodule // edge_trig_detect

// ===== verilog/periph_interrupt_dma_request_ctl.sv
/*
   Standard interrupt channel pending logic and generic peripheral interrupt and
   transfer request control, with an APB register port and a level interrupt.
   Assumes triggers, acknowledges and the counter-zero pulse are synchronous to mclk_i.
*/
// The implementer's own choice: the APB register port.
// Functional notes
// - Channel I0 pending flag sets on its trigger edge, clears on acknowledge.
// - Eight channel E to H pending flags set on trigger, clear on acknowledge.
// - Software writing ones into pending registers raises software interrupts.
// - Edges during a write to the edge configuration register set no flag.
// - Vector register bits 7:5 drive the vector address MSBs for E to L.
// - Vector register low five bits read 11110; bit 0 always zero.
// - Counter pointer bits 7:1 locate the transaction counter for transfers.
// - Counter pointer bit 0 selects memory (0) or register file (1).
// - Request pending bit sets on trigger, clears on acknowledge.
// - Software may write the request pending bit to one or zero.
// - Transfer request issued while pending only when the transfer mask is one.
// - Transfer mask clears when the counter reaches zero unless swap is active.
// - Bit 3 enables the end-of-block interrupt.
`timescale 1ns/1ps
module periph_interrupt_dma_request_ctl (
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [8:0]  chan_line_i,
   input  wire logic [8:0]  chan_ack_i,
   input  wire logic        periph_trig_i,
   input  wire logic        periph_ack_i,
   input  wire logic        count_zero_i,
   output logic      [8:0]  chan_pend_o,
   output logic      [2:0]  vector_msb_o,
   output logic             periph_int_req_o,
   output logic             dma_req_o,
   output logic      [2:0]  priority_o,
   output logic      [6:0]  counter_ptr_o,
   output logic             target_regfile_o,
   output logic             eob_int_o,
   output logic             irq_o
);
   logic [7:0]  eh_pend_reg;
   logic        i0_pend_reg;
   logic [2:0]  vec_msb_reg;
   logic [7:0]  cnt_ptr_reg;
   logic [5:0]  req_ctl_reg;
   logic [8:0]  edge_cfg_reg;
   logic        swap_reg;
   logic [2:0]  irq_stat_reg;
   logic [2:0]  irq_en_reg;
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic        dma_req_reg;
   logic        periph_int_reg;
   logic        eob_int_reg;
   logic        irq_reg;
   logic [8:0]  chan_event;
   logic        cfg_write_busy;
   logic        wr_en;
   logic        rd_phase;
   logic        wr_i0;
   logic        wr_eh;
   logic        wr_req;
   logic        eob_event;
   logic [2:0]  irq_events;
   logic [31:0] rd_mux;
   logic        rd_hit;

   // APB: the first access cycle prepares the answer, the second completes it.
   assign rd_phase = psel_i && penable_i && !pready_reg;
   assign wr_en    = psel_i && penable_i && pready_reg && pwrite_i;
   assign wr_i0    = wr_en && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::I0_PEND_IDX);
   assign wr_eh    = wr_en && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::EH_PEND_IDX);
   assign wr_req   = wr_en && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::REQ_CTL_IDX);

   // The whole write transfer counts, from setup to completion, so an edge can never
   // slip through the window in which the edge selection is half updated.
   assign cfg_write_busy = psel_i && pwrite_i &&
                           periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::EDGE_CFG_IDX);

   edge_trig_detect u_edge (
      .mclk_i     (mclk_i),
      .resetn_i   (resetn_i),
      .line_i     (chan_line_i),
      .rise_sel_i (edge_cfg_reg),
      .block_i    (cfg_write_busy),
      .event_o    (chan_event)
   );

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= rd_phase;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (paddr_i[11:2])
         periph_int_pkg::I0_PEND_IDX:  rd_mux[0] = i0_pend_reg;
         periph_int_pkg::EH_PEND_IDX:  rd_mux[7:0] = eh_pend_reg;
         periph_int_pkg::VEC_BASE_IDX: rd_mux[7:0] = {vec_msb_reg, periph_int_pkg::VEC_LOW_FIX};
         periph_int_pkg::CNT_PTR_IDX:  rd_mux[7:0] = cnt_ptr_reg;
         periph_int_pkg::REQ_CTL_IDX:  rd_mux[5:0] = req_ctl_reg;
         periph_int_pkg::EDGE_CFG_IDX: rd_mux[8:0] = edge_cfg_reg;
         periph_int_pkg::MODE_CTL_IDX: rd_mux[periph_int_pkg::MODE_SWAP_BIT] = swap_reg;
         periph_int_pkg::IRQ_STAT_IDX: rd_mux[2:0] = irq_stat_reg;
         periph_int_pkg::IRQ_EN_IDX:   rd_mux[2:0] = irq_en_reg;
         periph_int_pkg::IRQ_CLR_IDX:  rd_mux = 32'h0000_0000;
         default:                      rd_hit = 1'b0;
      endcase
      if (paddr_i[1:0] != 2'h0) begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (rd_phase) begin
         prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_mux;
         pslverr_reg <= !rd_hit;
      end else begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
   end

   // Hardware sets win over acknowledges and over software writes of zero.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         i0_pend_reg <= 1'b0;
      end else begin
         i0_pend_reg <= (i0_pend_reg && !chan_ack_i[8]) || chan_event[8] || (wr_i0 && pwdata_i[0]);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         eh_pend_reg <= periph_int_pkg::PEND_RST;
      end else begin
         eh_pend_reg <= (eh_pend_reg & ~chan_ack_i[7:0]) | chan_event[7:0] |
                        (wr_eh ? pwdata_i[7:0] : 8'h00);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vec_msb_reg  <= periph_int_pkg::VEC_MSB_RST;
         cnt_ptr_reg  <= periph_int_pkg::CNT_PTR_RST;
         edge_cfg_reg <= periph_int_pkg::EDGE_CFG_RST;
         swap_reg     <= 1'b0;
         irq_en_reg   <= periph_int_pkg::IRQ_RST;
      end else if (wr_en) begin
         if (periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::VEC_BASE_IDX)) begin
            vec_msb_reg <= pwdata_i[7:5];
         end
         if (periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::CNT_PTR_IDX)) begin
            cnt_ptr_reg <= pwdata_i[7:0];
         end
         if (periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::EDGE_CFG_IDX)) begin
            edge_cfg_reg <= pwdata_i[8:0];
         end
         if (periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::MODE_CTL_IDX)) begin
            swap_reg <= pwdata_i[periph_int_pkg::MODE_SWAP_BIT];
         end
         if (periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::IRQ_EN_IDX)) begin
            irq_en_reg <= pwdata_i[2:0];
         end
      end
   end

   // Request control: pending bit, transfer mask, end-of-block mask, priority.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_ctl_reg <= periph_int_pkg::REQ_CTL_RST;
      end else begin
         if (wr_req) begin
            req_ctl_reg[4:0] <= pwdata_i[4:0];
         end else if (count_zero_i && !swap_reg) begin
            req_ctl_reg[periph_int_pkg::REQ_DMASK_BIT] <= 1'b0;
         end
         // A trigger outranks a software write, which outranks an acknowledge, so no event is lost.
         if (periph_trig_i) begin
            req_ctl_reg[periph_int_pkg::REQ_PEND_BIT] <= 1'b1;
         end else if (wr_req) begin
            req_ctl_reg[periph_int_pkg::REQ_PEND_BIT] <= pwdata_i[periph_int_pkg::REQ_PEND_BIT];
         end else if (periph_ack_i) begin
            req_ctl_reg[periph_int_pkg::REQ_PEND_BIT] <= 1'b0;
         end
      end
   end

   assign eob_event  = count_zero_i && req_ctl_reg[periph_int_pkg::REQ_EOB_BIT];
   assign irq_events = {eob_event, periph_trig_i, |chan_event};

   // A clear written in the same cycle as an event loses, so that event stays visible to software.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_stat_reg <= periph_int_pkg::IRQ_RST;
      end else if (wr_en && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::IRQ_CLR_IDX)) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata_i[2:0]) | irq_events;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_events;
      end
   end

   // Requests are registered so every output leaves a flop; they trail the control bits by one cycle.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dma_req_reg    <= 1'b0;
         periph_int_reg <= 1'b0;
         eob_int_reg    <= 1'b0;
         irq_reg        <= 1'b0;
      end else begin
         dma_req_reg    <= req_ctl_reg[periph_int_pkg::REQ_PEND_BIT] &&
                           req_ctl_reg[periph_int_pkg::REQ_DMASK_BIT];
         periph_int_reg <= req_ctl_reg[periph_int_pkg::REQ_PEND_BIT] &&
                           !req_ctl_reg[periph_int_pkg::REQ_DMASK_BIT];
         eob_int_reg    <= eob_event;
         irq_reg        <= |(irq_stat_reg & irq_en_reg);
      end
   end

   assign prdata_o         = prdata_reg;
   assign pready_o         = pready_reg;
   assign pslverr_o        = pslverr_reg;
   assign chan_pend_o      = {i0_pend_reg, eh_pend_reg};
   assign vector_msb_o     = vec_msb_reg;
   assign periph_int_req_o = periph_int_reg;
   assign dma_req_o        = dma_req_reg;
   assign priority_o       = req_ctl_reg[2:0];
   assign counter_ptr_o    = cnt_ptr_reg[7:1];
   assign target_regfile_o = cnt_ptr_reg[periph_int_pkg::CNT_SEL_BIT];
   assign eob_int_o        = eob_int_reg;
   assign irq_o            = irq_reg;

   // The checks below watch the pending, request and register behaviour from inside the block.
   i0_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      chan_event[8] |=> chan_pend_o[8]) else $error("I0 trigger did not set its pending flag");

   i0_ack_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      chan_ack_i[8] && !chan_event[8] && !(wr_i0 && pwdata_i[0]) |=> !chan_pend_o[8])
      else $error("I0 acknowledge did not clear pending flag");

   eh_flags_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !wr_eh |=> chan_pend_o[7:0] == (($past(eh_pend_reg) & ~$past(chan_ack_i[7:0])) | $past(chan_event[7:0])))
      else $error("E to H pending flags wrong after events");

   sw_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_eh |=> (chan_pend_o[7:0] & $past(pwdata_i[7:0])) == $past(pwdata_i[7:0]))
      else $error("Software write did not set pending flags");

   cfg_block_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      cfg_write_busy && !wr_eh && !wr_i0 |=>
      chan_pend_o == ($past(chan_pend_o) & ~$past(chan_ack_i)))
      else $error("Pending flag set during edge configuration write");

   vec_msb_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_en && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::VEC_BASE_IDX) |=>
      vector_msb_o == $past(pwdata_i[7:5]) ##1 vector_msb_o == $past(pwdata_i[7:5], 2))
      else $error("Vector MSBs not taken from write");

   vec_low_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      rd_phase && !pwrite_i && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::VEC_BASE_IDX) |=>
      pready_o && prdata_o[4:0] == 5'h1E) else $error("Vector low bits not 11110");

   target_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_en && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::CNT_PTR_IDX) |=>
      target_regfile_o == $past(pwdata_i[0]) && counter_ptr_o == $past(pwdata_i[7:1]))
      else $error("Counter pointer write not applied");

   pend_sw_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_req && !periph_trig_i |=> req_ctl_reg[5] == $past(pwdata_i[5]))
      else $error("Software write of request pending bit lost");

   dma_req_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      req_ctl_reg[5] && req_ctl_reg[4] |=> dma_req_o && !periph_int_req_o)
      else $error("Transfer request missing while pending and unmasked");

   dm_zero_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      count_zero_i && !swap_reg && !wr_req |=> !req_ctl_reg[4] ##1 !dma_req_o)
      else $error("Transfer mask not cleared at counter zero");

   dm_swap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      count_zero_i && swap_reg && req_ctl_reg[4] && !wr_req |=> req_ctl_reg[4])
      else $error("Transfer mask cleared in swap mode");

   eob_int_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      count_zero_i |=> eob_int_o == $past(req_ctl_reg[3]))
      else $error("End-of-block interrupt not gated by its mask");

   irq_out_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      |(irq_stat_reg & irq_en_reg) |=> irq_o) else $error("Interrupt output not raised");

   apb_ready_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      rd_phase |=> pready_o ##1 !pready_o) else $error("APB ready not a single cycle");

   trig_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      periph_trig_i |=> req_ctl_reg[5])
      else $error("Trigger did not set the request pending bit");

   ack_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      periph_ack_i && !periph_trig_i && !wr_req |=> !req_ctl_reg[5])
      else $error("Acknowledge did not clear the request pending bit");

   int_req_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      req_ctl_reg[5] && !req_ctl_reg[4] |=> periph_int_req_o && !dma_req_o)
      else $error("Masked request raised a transfer request");

   no_req_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !req_ctl_reg[5] |=> !dma_req_o && !periph_int_req_o)
      else $error("Request raised with nothing pending");

   prio_out_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_req |=> priority_o == $past(pwdata_i[2:0]))
      else $error("Priority level not presented after write");

   edge_drop_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      cfg_write_busy |-> chan_event == 9'h000)
      else $error("Edge event passed during edge configuration write");

   i0_sw_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_i0 && pwdata_i[0] |=> chan_pend_o[8])
      else $error("Software write did not set the I0 pending flag");

   ptr_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !(wr_en && periph_int_pkg::reg_hit(paddr_i, periph_int_pkg::CNT_PTR_IDX)) |=> $stable(cnt_ptr_reg))
      else $error("Counter pointer changed without a software write");

   apb_err_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      rd_phase && !rd_hit |=> pslverr_o && prdata_o == 32'h0000_0000)
      else $error("Unmapped access not answered with an error");
endmodule // periph_interrupt_dma_request_ctl

// ===== bench/cpu_ack_model.sv
/*
   Model of the CPU acknowledge and transfer logic facing the request controller.
   Assumes the controller's request outputs are registered on mclk_i.
*/
`timescale 1ns/1ps
module cpu_ack_model (
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   input  wire logic       enable_i,
   input  wire logic [3:0] delay_i,
   input  wire logic [3:0] xfer_count_i,
   input  wire logic [8:0] chan_pend_i,
   input  wire logic       dma_req_i,
   input  wire logic       int_req_i,
   output logic      [8:0] chan_ack_o,
   output logic            periph_ack_o,
   output logic            count_zero_o
);
   logic [3:0] wait_reg;
   logic [3:0] done_reg;

   // For delay_i other than 13 or 14, where delay_i + 3 wraps, the back-off outlasts the registered request, so no request is taken twice.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_reg     <= 4'h0;
         done_reg     <= 4'h0;
         chan_ack_o   <= 9'h000;
         periph_ack_o <= 1'b0;
         count_zero_o <= 1'b0;
      end else begin
         chan_ack_o   <= 9'h000;
         periph_ack_o <= 1'b0;
         count_zero_o <= 1'b0;
         if (!enable_i || (chan_pend_i == 9'h000 && !dma_req_i && !int_req_i)) begin
            wait_reg <= delay_i;
         end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
         end else begin
            wait_reg <= delay_i + 4'h3;
            if (dma_req_i || int_req_i) begin
               periph_ack_o <= 1'b1;
               if (dma_req_i && done_reg + 4'h1 >= xfer_count_i) begin
                  count_zero_o <= 1'b1;
                  done_reg     <= 4'h0;
               end else if (dma_req_i) begin
                  done_reg <= done_reg + 4'h1;
               end
            end else begin
               chan_ack_o <= chan_pend_i & (~chan_pend_i + 9'h001);
            end
         end
      end
   end
endmodule // cpu_ack_model

// ===== bench/tb_peripheral_interrupt_dma_request_ctl.sv
/*
   Self-checking testbench for the peripheral interrupt and transfer request controller.
   Assumes an APB master in this bench and the acknowledge model beside the controller.
*/
`timescale 1ns/1ps
module tb_peripheral_interrupt_dma_request_ctl;
   logic        mclk_i, resetn_i, psel_i, penable_i, pwrite_i, err, seen_eob, model_en;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic        pready_o, pslverr_o, periph_trig_i, periph_ack_i, count_zero_i;
   logic [8:0]  chan_line_i, chan_ack_i, chan_pend_o;
   logic [2:0]  vector_msb_o, priority_o;
   logic        periph_int_req_o, dma_req_o, target_regfile_o, eob_int_o, irq_o;
   logic [6:0]  counter_ptr_o;
   logic [3:0]  model_delay;
   int          errors, check_count;

   periph_interrupt_dma_request_ctl dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .chan_line_i(chan_line_i),
      .chan_ack_i(chan_ack_i), .periph_trig_i(periph_trig_i), .periph_ack_i(periph_ack_i),
      .count_zero_i(count_zero_i), .chan_pend_o(chan_pend_o), .vector_msb_o(vector_msb_o),
      .periph_int_req_o(periph_int_req_o), .dma_req_o(dma_req_o), .priority_o(priority_o),
      .counter_ptr_o(counter_ptr_o), .target_regfile_o(target_regfile_o), .eob_int_o(eob_int_o),
      .irq_o(irq_o));

   cpu_ack_model model_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .enable_i(model_en),
      .delay_i(model_delay), .xfer_count_i(4'h1), .chan_pend_i(chan_pend_o), .dma_req_i(dma_req_o),
      .int_req_i(periph_int_req_o), .chan_ack_o(chan_ack_i), .periph_ack_o(periph_ack_i),
      .count_zero_o(count_zero_i));

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge mclk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= {idx, 2'h0};
      pwdata_i  <= wd;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge mclk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h00000000);
      check(rd, exp);
   endtask

   // Lets the model acknowledge until every request has dropped.
   task automatic serve;
      int n;
      model_en <= 1'b1;
      for (n = 0; n < 300 && (chan_pend_o !== 9'h000 || dma_req_o !== 1'b0 || periph_int_req_o !== 1'b0); n++)
         @(posedge mclk_i);
      cyc(3);
      model_en <= 1'b0;
      check(32'(chan_pend_o), 32'h00000000);
   endtask

   task automatic t_reset;
      rd_chk(periph_int_pkg::I0_PEND_IDX, 32'h00000000);
      rd_chk(periph_int_pkg::EH_PEND_IDX, 32'h00000000);
      rd_chk(periph_int_pkg::VEC_BASE_IDX, 32'h0000001E);
      apb(1'b0, 10'h3FF, 32'h00000000);
      check(32'(err), 32'h00000001);
      apb(1'b1, periph_int_pkg::VEC_BASE_IDX, 32'h000000FF);
      rd_chk(periph_int_pkg::VEC_BASE_IDX, 32'h000000FE);
      check(32'(vector_msb_o), 32'h00000007);
      apb(1'b1, periph_int_pkg::CNT_PTR_IDX, 32'h000000B7);
      cyc(1);
      check(32'({counter_ptr_o, target_regfile_o}), 32'h000000B7);
      apb(1'b1, periph_int_pkg::CNT_PTR_IDX, 32'h0000006A);
      cyc(1);
      check(32'({counter_ptr_o, target_regfile_o}), 32'h0000006A);
   endtask

   task automatic t_channels;
      model_delay <= 4'h5;
      apb(1'b1, periph_int_pkg::EDGE_CFG_IDX, 32'h000001FF);
      fork
         apb(1'b1, periph_int_pkg::EDGE_CFG_IDX, 32'h000001FE);
         begin
            repeat (2) @(posedge mclk_i);
            chan_line_i <= 9'h001;
         end
      join
      cyc(3);
      check(32'(chan_pend_o), 32'h00000000);
      @(posedge mclk_i);
      chan_line_i <= 9'h000;
      cyc(3);
      check(32'(chan_pend_o), 32'h00000001);
      @(posedge mclk_i);
      chan_line_i <= 9'h100;
      cyc(3);
      check(32'(chan_pend_o), 32'h00000101);
      rd_chk(periph_int_pkg::I0_PEND_IDX, 32'h00000001);
      serve;
      apb(1'b1, periph_int_pkg::I0_PEND_IDX, 32'h00000001);
      apb(1'b1, periph_int_pkg::EH_PEND_IDX, 32'h000000A5);
      cyc(1);
      check(32'(chan_pend_o), 32'h000001A5);
      rd_chk(periph_int_pkg::EH_PEND_IDX, 32'h000000A5);
      serve;
   endtask

   task automatic t_periph;
      model_delay <= 4'h0;
      apb(1'b1, periph_int_pkg::IRQ_CLR_IDX, 32'h00000007);
      apb(1'b1, periph_int_pkg::IRQ_EN_IDX, 32'h00000004);
      apb(1'b1, periph_int_pkg::REQ_CTL_IDX, 32'h00000005);
      periph_trig_i <= 1'b1;
      @(posedge mclk_i);
      periph_trig_i <= 1'b0;
      cyc(2);
      check(32'({periph_int_req_o, dma_req_o, priority_o}), 32'h00000015);
      rd_chk(periph_int_pkg::REQ_CTL_IDX, 32'h00000025);
      apb(1'b1, periph_int_pkg::REQ_CTL_IDX, 32'h00000005);
      cyc(2);
      check(32'(periph_int_req_o), 32'h00000000);
      apb(1'b1, periph_int_pkg::REQ_CTL_IDX, 32'h0000003D);
      cyc(2);
      check(32'({periph_int_req_o, dma_req_o}), 32'h00000001);
      serve;
      rd_chk(periph_int_pkg::REQ_CTL_IDX, 32'h0000000D);
      check(32'(seen_eob), 32'h00000001);
      apb(1'b0, periph_int_pkg::IRQ_STAT_IDX, 32'h00000000);
      check(rd & 32'h00000004, 32'h00000004);
      check(32'(irq_o), 32'h00000001);
      apb(1'b1, periph_int_pkg::IRQ_CLR_IDX, 32'h00000004);
      cyc(2);
      check(32'(irq_o), 32'h00000000);
      apb(1'b1, periph_int_pkg::IRQ_EN_IDX, 32'h00000002);
      cyc(2);
      check(32'(irq_o), 32'h00000001);
      apb(1'b1, periph_int_pkg::IRQ_CLR_IDX, 32'h00000007);
      cyc(2);
      check(32'(irq_o), 32'h00000000);
      apb(1'b1, periph_int_pkg::MODE_CTL_IDX, 32'h00000001);
      apb(1'b1, periph_int_pkg::REQ_CTL_IDX, 32'h0000003D);
      serve;
      rd_chk(periph_int_pkg::REQ_CTL_IDX, 32'h0000001D);
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) if (eob_int_o === 1'b1) seen_eob <= 1'b1;

   initial begin
      resetn_i = 1'b0;
      {psel_i, penable_i, pwrite_i, periph_trig_i, model_en, seen_eob} = 6'h00;
      paddr_i = 12'h000;
      pwdata_i = 32'h00000000;
      chan_line_i = 9'h000;
      model_delay = 4'h5;
      errors = 0;
      check_count = 0;
      repeat (2) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_reset;
      t_channels;
      t_periph;
      give_verdict;
   end

   initial begin
      repeat (6000) @(posedge mclk_i);
      errors++;
      give_verdict;
   end
endmodule // tb_peripheral_interrupt_dma_request_ctl
